// ==== common/tgaic_cfg.svh ====
/*
 * Constants for the first-general-register function control of timer channels 1 to 3:
 * register offsets, field positions, widths and reset values.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef TGAIC_CFG_SVH
`define TGAIC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// widths
`define TGAIC_ADDR_W      8
`define TGAIC_DATA_W      16
`define TGAIC_CNT_W       16
`define TGAIC_NUM_CH      3
`define TGAIC_FUNC_W      4

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses)
`define TGAIC_OFS_FUNC1   8'h00
`define TGAIC_OFS_FUNC2   8'h04
`define TGAIC_OFS_FUNC3   8'h08
`define TGAIC_OFS_GR1     8'h0C
`define TGAIC_OFS_GR2     8'h10
`define TGAIC_OFS_GR3     8'h14
`define TGAIC_OFS_STATUS  8'h18

////////////////////////////////////////////////////////////////////////////////
// status word field positions
`define TGAIC_ST_PIN_LSB  0
`define TGAIC_ST_IN_LSB   3
`define TGAIC_ST_EVT_LSB  6
`define TGAIC_ST_OE_LSB   9

////////////////////////////////////////////////////////////////////////////////
// reset values and cascade availability (bit per channel 1..3)
`define TGAIC_FUNC_RST    4'h0
`define TGAIC_GR_RST      16'h0000
`define TGAIC_CASC_MASK   3'h5

`endif

// ==== common/tgaic_pkg.sv ====
/*
 * Types for the first-general-register function control block.
 * Assumes tgaic_cfg.svh is on the include path.
 */
`include "tgaic_cfg.svh"

package tgaic_pkg;

	// 4-bit function field, top bit first
	typedef struct packed {
		logic func_a_mode_bit;
		logic func_a_level_bit;
		logic func_a_act_hi;
		logic func_a_act_lo;
	} tgaic_func_type;

	// one register bus request
	typedef struct packed {
		logic                       wr;
		logic                       rd;
		logic [`TGAIC_ADDR_W-1:0]   addr;
		logic [`TGAIC_DATA_W-1:0]   wdata;
	} tgaic_bus_req_type;

	// decoded role of a general register
	typedef enum logic [3:0] {
		TGAIC_CMP_OFF  = 4'h1,
		TGAIC_CMP_ON   = 4'h2,
		TGAIC_CAP_PIN  = 4'h4,
		TGAIC_CAP_CASC = 4'h8
	} tgaic_role_type;

endpackage

// ==== hw/tgaic_sync.sv ====
/*
 * Two-flip-flop synchroniser for a group of asynchronous pin levels.
 * Assumes core_clk is the single block clock and nrst an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module tgaic_sync #(
	parameter int W = 1
) (
	input  logic         core_clk,
	input  logic         nrst,
	input  logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_q;
	logic [W-1:0] s2_d;

	if (W < 1) begin : g_bad_w
		$error("tgaic_sync: W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage
	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign dout = s2_q;

endmodule

// ==== hw/tgaic_edge.sv ====
/*
 * Edge selector for one channel pin: rising, falling or both edges give a trigger pulse.
 * Assumes lvl is already synchronised to core_clk.
 */
`timescale 1ns/1ps

module tgaic_edge (
	input  logic core_clk,
	input  logic nrst,
	input  logic lvl,
	input  logic sel_both,
	input  logic sel_fall,
	output logic trig
);

	logic prev_q;
	logic prev_d;
	logic rise;
	logic fall;

	////////////////////////////////////////////////////////////////////////////////
	// edge detect against last sampled level
	always_comb begin
		prev_d = lvl;
		rise   = lvl & ~prev_q;
		fall   = ~lvl & prev_q;
		if (sel_both)
			trig = rise | fall;
		else if (sel_fall)
			trig = fall;
		else
			trig = rise;
	end

	// reset low matches the synchroniser reset, so no false edge at release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			prev_q <= 1'h0;
		else
			prev_q <= prev_d;
	end

endmodule

// ==== hw/tgaic_top.sv ====
/*
 * Function control of the first general register of timer channels 1, 2 and 3.
 * Each register works as output compare (pin drive 0, 1 or toggle on match) or as
 * input capture (pin edge, or cascaded internal source on channels 1 and 3), steered by a 4-bit field.
 * Assumes the counter core supplies the count values on core_clk, the channel 0 and
 * channel 4 event inputs are one-cycle pulses on core_clk, and the pin inputs are
 * asynchronous. Registers are reached over a plain strobe port with read data one
 * cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "tgaic_cfg.svh"

// Functional notes
// - field 0000 after reset: compare, pin off; 0001 starts low, drives low on match
// - compare with low bits 10 drives the pin high on each match
// - compare with low bits 11 toggles the pin on each match
// - bit 2 picks the initial pin level; low bits 00 keep the pin undriven
// - top bit set makes capture; pin source with low bits 00 captures rising edges
// - pin capture with low bits 01 captures falling edges
// - pin capture with bit 1 set captures both edges, bit 0 ignored
// - channel 1 with bits 3 and 2 set captures on channel 0 first register events
// - channel 3 with bits 3 and 2 set captures on each channel 4 count tick
// - channel 2 ignores bit 2 in capture; always pin sourced
// - channel 0 third register events are suppressed while buffer mode is set
module tgaic_top #(
	parameter int CNT_W = `TGAIC_CNT_W
) (
	input  logic                                      core_clk,
	input  logic                                      nrst,
	input  tgaic_pkg::tgaic_bus_req_type              bus_req,
	output logic [`TGAIC_DATA_W-1:0]                  bus_rdata,
	input  logic [`TGAIC_NUM_CH-1:0][CNT_W-1:0]       ch_count,
	input  logic                                      ch0_first_evt,
	input  logic                                      ch4_count_tick,
	input  logic                                      buffer_mode_first_pair,
	input  logic                                      ch0_third_raw_evt,
	output logic                                      ch0_third_evt,
	input  logic [`TGAIC_NUM_CH-1:0]                  io_pin_in,
	output logic [`TGAIC_NUM_CH-1:0]                  io_pin_out,
	output logic [`TGAIC_NUM_CH-1:0]                  io_pin_oe,
	output logic [`TGAIC_NUM_CH-1:0]                  chan_evt,
	output logic [`TGAIC_NUM_CH-1:0][CNT_W-1:0]       gr_value
);

	////////////////////////////////////////////////////////////////////////////////
	// constants

	localparam int NUM_CH = `TGAIC_NUM_CH;
	localparam int DATA_W = `TGAIC_DATA_W;
	localparam int ADDR_W = `TGAIC_ADDR_W;
	localparam int FUNC_W = `TGAIC_FUNC_W;

	localparam logic [ADDR_W-1:0] FUNC_OFS [NUM_CH] = '{`TGAIC_OFS_FUNC1, `TGAIC_OFS_FUNC2, `TGAIC_OFS_FUNC3};
	localparam logic [ADDR_W-1:0] GR_OFS   [NUM_CH] = '{`TGAIC_OFS_GR1, `TGAIC_OFS_GR2, `TGAIC_OFS_GR3};
	localparam logic [ADDR_W-1:0] ST_OFS            = `TGAIC_OFS_STATUS;
	localparam logic [NUM_CH-1:0] CASC_MASK         = `TGAIC_CASC_MASK;
	localparam logic [CNT_W-1:0]  GR_RST            = CNT_W'(`TGAIC_GR_RST);

	// the status word must hold four fields of one bit per channel
	if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_cnt
		$error("tgaic_top: CNT_W must lie between 2 and the data width");
	end
	if (`TGAIC_ST_OE_LSB + NUM_CH > DATA_W) begin : g_bad_status
		$error("tgaic_top: status fields do not fit the data width");
	end

	////////////////////////////////////////////////////////////////////////////////
	// role decode shared by the current and the next function value

	function automatic tgaic_pkg::tgaic_role_type role_of(
		input tgaic_pkg::tgaic_func_type f,
		input logic                      casc
	);
		tgaic_pkg::tgaic_role_type r;
		if (!f.func_a_mode_bit) begin
			if ({f.func_a_act_hi, f.func_a_act_lo} == 2'h0)
				r = tgaic_pkg::TGAIC_CMP_OFF;
			else
				r = tgaic_pkg::TGAIC_CMP_ON;
		end else if (f.func_a_level_bit && casc) begin
			r = tgaic_pkg::TGAIC_CAP_CASC;
		end else begin
			r = tgaic_pkg::TGAIC_CAP_PIN;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	tgaic_pkg::tgaic_func_type  func_q   [NUM_CH];
	tgaic_pkg::tgaic_func_type  func_d   [NUM_CH];
	tgaic_pkg::tgaic_func_type  wfunc;
	tgaic_pkg::tgaic_role_type  role     [NUM_CH];

	logic [CNT_W-1:0]   gr_q      [NUM_CH];
	logic [CNT_W-1:0]   gr_d      [NUM_CH];
	logic [NUM_CH-1:0]  pin_q;
	logic [NUM_CH-1:0]  pin_d;
	logic [NUM_CH-1:0]  oe_q;
	logic [NUM_CH-1:0]  oe_d;
	logic [NUM_CH-1:0]  eq_q;
	logic [NUM_CH-1:0]  eq_d;
	logic [NUM_CH-1:0]  flag_q;
	logic [NUM_CH-1:0]  flag_d;
	logic [NUM_CH-1:0]  evt_q;
	logic [NUM_CH-1:0]  evt_d;
	logic               third_q;
	logic               third_d;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  rdata_d;

	logic [NUM_CH-1:0]  func_wr;
	logic [NUM_CH-1:0]  gr_wr;
	logic               st_wr;
	logic [NUM_CH-1:0]  match;
	logic [NUM_CH-1:0]  cap_trig;
	logic [NUM_CH-1:0]  pin_trig;
	logic [NUM_CH-1:0]  pin_sync;
	logic [NUM_CH-1:0]  casc_src;
	logic [DATA_W-1:0]  status_word;
	logic [NUM_CH-1:0]  flag_clr;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and per-channel edge selectors

	tgaic_sync #(
		.W        (NUM_CH)
	) i_tgaic_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.din      (io_pin_in),
		.dout     (pin_sync)
	);

	for (genvar g = 0; g < NUM_CH; g++) begin : g_edge
		tgaic_edge i_tgaic_edge (
			.core_clk (core_clk),
			.nrst     (nrst),
			.lvl      (pin_sync[g]),
			.sel_both (func_q[g].func_a_act_hi),
			.sel_fall (func_q[g].func_a_act_lo),
			.trig     (pin_trig[g])
		);
	end

	// cascade sources: channel 1 from channel 0, none for channel 2, channel 3 from channel 4
	assign casc_src = {ch4_count_tick, 1'h0, ch0_first_evt};

	////////////////////////////////////////////////////////////////////////////////
	// register bus decode and read mux

	assign wfunc = tgaic_pkg::tgaic_func_type'(bus_req.wdata[FUNC_W-1:0]);

	// status word: pin levels, synced inputs, sticky event flags, drive enables
	always_comb begin
		status_word = '0;
		status_word[`TGAIC_ST_PIN_LSB +: NUM_CH] = pin_q;
		status_word[`TGAIC_ST_IN_LSB  +: NUM_CH] = pin_sync;
		status_word[`TGAIC_ST_EVT_LSB +: NUM_CH] = flag_q;
		status_word[`TGAIC_ST_OE_LSB  +: NUM_CH] = oe_q;
	end

	// unmapped reads answer zero; unmapped writes are dropped
	always_comb begin
		func_wr  = '0;
		gr_wr    = '0;
		rdata_d  = '0;
		st_wr    = bus_req.wr && (bus_req.addr == ST_OFS);
		for (int i = 0; i < NUM_CH; i++) begin
			if (bus_req.wr && (bus_req.addr == FUNC_OFS[i]))
				func_wr[i] = 1'h1;
			if (bus_req.wr && (bus_req.addr == GR_OFS[i]))
				gr_wr[i] = 1'h1;
			if (bus_req.rd && (bus_req.addr == FUNC_OFS[i]))
				rdata_d[FUNC_W-1:0] = func_q[i];
			if (bus_req.rd && (bus_req.addr == GR_OFS[i]))
				rdata_d[CNT_W-1:0] = gr_q[i];
		end
		if (bus_req.rd && (bus_req.addr == ST_OFS))
			rdata_d = status_word;
		flag_clr = st_wr ? bus_req.wdata[`TGAIC_ST_EVT_LSB +: NUM_CH] : '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// role, compare match and capture trigger per channel

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			role[i]     = role_of(func_q[i], CASC_MASK[i]);
			eq_d[i]     = (ch_count[i] == gr_q[i]);
			match[i]    = 1'h0;
			cap_trig[i] = 1'h0;
			// a match is the first cycle of equality, so a parked counter fires once
			unique case (role[i])
				tgaic_pkg::TGAIC_CMP_OFF,
				tgaic_pkg::TGAIC_CMP_ON: begin
					match[i] = eq_d[i] & ~eq_q[i];
				end
				tgaic_pkg::TGAIC_CAP_PIN: begin
					cap_trig[i] = pin_trig[i];
				end
				tgaic_pkg::TGAIC_CAP_CASC: begin
					cap_trig[i] = casc_src[i];
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state of function, pin, general register and flags

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			func_d[i] = func_wr[i] ? wfunc : func_q[i];
			// drive enable follows the new setting, so it changes with the written field
			oe_d[i] = (role_of(func_d[i], CASC_MASK[i]) == tgaic_pkg::TGAIC_CMP_ON);

			// a write in compare mode loads the initial level even with drive off
			pin_d[i] = pin_q[i];
			if (func_wr[i] && !wfunc.func_a_mode_bit) begin
				pin_d[i] = wfunc.func_a_level_bit;
			end else if (match[i] && (role[i] == tgaic_pkg::TGAIC_CMP_ON)) begin
				unique case ({func_q[i].func_a_act_hi, func_q[i].func_a_act_lo})
					2'h1:    pin_d[i] = 1'h0;
					2'h2:    pin_d[i] = 1'h1;
					2'h3:    pin_d[i] = ~pin_q[i];
					default: pin_d[i] = pin_q[i];
				endcase
			end

			// hardware capture wins over a software write in the same cycle
			if (cap_trig[i])
				gr_d[i] = ch_count[i];
			else if (gr_wr[i])
				gr_d[i] = bus_req.wdata[CNT_W-1:0];
			else
				gr_d[i] = gr_q[i];

			evt_d[i]  = match[i] | cap_trig[i];
			// set wins over write-one-to-clear
			flag_d[i] = evt_d[i] | (flag_q[i] & ~flag_clr[i]);
		end
		third_d = ch0_third_raw_evt & ~buffer_mode_first_pair;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				func_q[i] <= tgaic_pkg::tgaic_func_type'(`TGAIC_FUNC_RST);
				gr_q[i]   <= GR_RST;
			end
			pin_q   <= '0;
			oe_q    <= '0;
			eq_q    <= '0;
			flag_q  <= '0;
			evt_q   <= '0;
			third_q <= 1'h0;
			rdata_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				func_q[i] <= func_d[i];
				gr_q[i]   <= gr_d[i];
			end
			pin_q   <= pin_d;
			oe_q    <= oe_d;
			eq_q    <= eq_d;
			flag_q  <= flag_d;
			evt_q   <= evt_d;
			third_q <= third_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign bus_rdata     = rdata_q;
	assign io_pin_out    = pin_q;
	assign io_pin_oe     = oe_q;
	assign chan_evt      = evt_q;
	assign ch0_third_evt = third_q;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_gr_out
		assign gr_value[g] = gr_q[g];
	end

endmodule

// ==== verification/tgaic_props.sv ====
/* tgaic_props: port checker for tgaic_top.
 * Assumes the bind below and tgaic_cfg.svh on the include path. */
`timescale 1ns/1ps
`include "tgaic_cfg.svh"

module tgaic_props #(
	parameter int CNT_W = 16
) (
	input logic                                core_clk,
	input logic                                nrst,
	input tgaic_pkg::tgaic_bus_req_type        bus_req,
	input logic [`TGAIC_DATA_W-1:0]            bus_rdata,
	input logic [`TGAIC_NUM_CH-1:0][CNT_W-1:0] ch_count,
	input logic                                ch0_first_evt,
	input logic                                ch4_count_tick,
	input logic                                buffer_mode_first_pair,
	input logic                                ch0_third_raw_evt,
	input logic                                ch0_third_evt,
	input logic [`TGAIC_NUM_CH-1:0]            io_pin_out,
	input logic [`TGAIC_NUM_CH-1:0]            io_pin_oe,
	input logic [`TGAIC_NUM_CH-1:0]            chan_evt,
	input logic [`TGAIC_NUM_CH-1:0][CNT_W-1:0] gr_value
);
	logic [3:0] f1_q, f1_d, f3_q, f3_d;
	logic       w1, w3;

	// shadow of the ch1 and ch3 function fields
	assign w1 = bus_req.wr && bus_req.addr == `TGAIC_OFS_FUNC1;
	assign w3 = bus_req.wr && bus_req.addr == `TGAIC_OFS_FUNC3;
	always_comb begin
		f1_d = w1 ? bus_req.wdata[3:0] : f1_q;
		f3_d = w3 ? bus_req.wdata[3:0] : f3_q;
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			f1_q <= `TGAIC_FUNC_RST;
			f3_q <= `TGAIC_FUNC_RST;
		end else begin
			f1_q <= f1_d;
			f3_q <= f3_d;
		end
	end

	////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
		else $error("read data outside read slot");
	init_lvl_a: assert property (w1 && !bus_req.wdata[3] && bus_req.wdata[1:0] != 2'h0
		|=> io_pin_oe[0] && io_pin_out[0] == $past(bus_req.wdata[2])) else $error("bad initial level");
	cap_undriven_a: assert property (w1 && bus_req.wdata[3] |=> !io_pin_oe[0])
		else $error("pin driven in capture");
	pin_cause_a: assert property (io_pin_out[0] != $past(io_pin_out[0])
		|-> chan_evt[0] || $past(bus_req.wr)) else $error("pin moved without cause");
	drive_lo_a: assert property (chan_evt[0] && f1_q == 4'h1 && !$past(bus_req.wr)
		|-> !io_pin_out[0]) else $error("match did not drive low");
	drive_hi_a: assert property (chan_evt[0] && !f1_q[3] && f1_q[1:0] == 2'h2
		&& !$past(bus_req.wr) |-> io_pin_out[0]) else $error("match did not drive high");
	pin_toggle_a: assert property (chan_evt[0] && !f1_q[3] && f1_q[1:0] == 2'h3
		&& !$past(bus_req.wr) |-> io_pin_out[0] != $past(io_pin_out[0])) else $error("no toggle");
	cap_copy_a: assert property (chan_evt[0] && f1_q[3] && !$past(bus_req.wr)
		|-> gr_value[0] == $past(ch_count[0])) else $error("capture value wrong");
	casc_ch1_a: assert property (f1_q[3:2] == 2'h3 && ch0_first_evt && !bus_req.wr
		|=> chan_evt[0] && gr_value[0] == $past(ch_count[0])) else $error("ch1 cascade missed");
	casc_ch3_a: assert property (f3_q[3:2] == 2'h3 && ch4_count_tick && !bus_req.wr
		|=> chan_evt[2] && gr_value[2] == $past(ch_count[2])) else $error("ch3 cascade missed");
	third_gate_a: assert property ($past(nrst)
		|-> ch0_third_evt == $past(ch0_third_raw_evt && !buffer_mode_first_pair)) else $error("gate wrong");
endmodule

bind tgaic_top tgaic_props #(.CNT_W(CNT_W)) i_tgaic_props (.core_clk, .nrst, .bus_req, .bus_rdata,
	.ch_count, .ch0_first_evt, .ch4_count_tick, .buffer_mode_first_pair, .ch0_third_raw_evt,
	.ch0_third_evt, .io_pin_out, .io_pin_oe, .chan_evt, .gr_value);

// ==== verification/tgaic_pin_model.sv ====
/* tgaic_pin_model: the three channel pins outside the block.
 * Assumes the bench sets the level an outside source puts on each pin. */
`timescale 1ns/1ps

module tgaic_pin_model (
	input  logic [2:0] io_pin_out,
	input  logic [2:0] io_pin_oe,
	input  logic [2:0] ext_lvl,
	output logic [2:0] pin
);
	// block drive wins; an undriven pin follows the outside source
	assign pin = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_lvl);
endmodule

// ==== verification/tgaic_top_tb_top.sv ====
/* tgaic_top_tb_top: self-checking bench for tgaic_top.
 * Assumes tgaic_pkg compiled first and tgaic_cfg.svh on the include path. */
`timescale 1ns/1ps
`include "tgaic_cfg.svh"

`define CHK(g, e, m) begin samples_checked++; if (((g) & (m)) !== ((e) & (m))) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tgaic_top_tb_top;
	logic                         core_clk = 1'b0;
	logic                         nrst = 1'b0;
	tgaic_pkg::tgaic_bus_req_type bus_req = '0;
	logic [15:0]                  bus_rdata, r, g, e_m, m_m;
	logic [2:0][15:0]             cnt = {3{16'h0001}};
	logic [2:0][15:0]             grv;
	logic                         f0_evt = 1'b0, tick = 1'b0, bmode = 1'b0, raw = 1'b0, third, rd_d = 1'b0;
	logic [2:0]                   ext_lvl = '0, pin, pout, poe, cevt;
	logic [15:0]                  exp_q[$], msk_q[$];
	int                           mismatches = 0, samples_checked = 0, seed = 79650;

	tgaic_top i_tgaic_top (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.ch_count(cnt), .ch0_first_evt(f0_evt), .ch4_count_tick(tick), .buffer_mode_first_pair(bmode),
		.ch0_third_raw_evt(raw), .ch0_third_evt(third), .io_pin_in(pin), .io_pin_out(pout),
		.io_pin_oe(poe), .chan_evt(cevt), .gr_value(grv));
	tgaic_pin_model i_tgaic_pin_model (.io_pin_out(pout), .io_pin_oe(poe), .ext_lvl(ext_lvl), .pin(pin));

	initial forever #10 core_clk = ~core_clk;

	////////////////////////////////
	// one bus cycle; strobe dropped at the next edge, so calls never collide
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{w, !w, a, d};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one-cycle match of ch1 counter against its register
	task automatic hit();
		cnt[0] <= g;
		@(posedge core_clk);
		cnt[0] <= ~g;
	endtask
	task automatic pulse(input int k);
		f0_evt <= (k == 0);
		tick <= (k == 1);
		@(posedge core_clk);
		f0_evt <= 1'b0;
		tick <= 1'b0;
		idle(2);
	endtask
	function automatic logic lvl(input int c, input int n);
		case (c % 4)
			0: lvl = c[2];
			1: lvl = 1'b0;
			2: lvl = 1'b1;
			default: lvl = c[2] ^ (n == 0);
		endcase
	endfunction
	task automatic report_and_stop();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////
	// read data is due one cycle after the strobe; oldest note first
	always @(posedge core_clk) begin
		if (rd_d) begin
			e_m = exp_q.pop_front();
			m_m = msk_q.pop_front();
			`CHK(bus_rdata, e_m, m_m)
		end
		rd_d <= bus_req.rd;
	end
	// random third-register traffic keeps the gating checks busy
	always @(posedge core_clk) begin
		raw <= 1'($random(seed));
		bmode <= 1'($random(seed));
	end
	// hang guard
	initial begin
		idle(20000);
		mismatches++;
		$display("wrong value at %0t: run hung", $time);
		report_and_stop();
	end

	initial begin
		idle(12);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'(4 * i), 16'h0000, 16'hFFFF);
		// every compare code, two matches each
		g = 16'($random(seed));
		bus(1'b1, `TGAIC_OFS_GR1, g);
		cnt[0] <= ~g;
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, `TGAIC_OFS_FUNC1, 16'(c));
			rd(`TGAIC_OFS_STATUS, {6'h00, (c % 4 != 0), 8'h00, c[2]}, 16'h0201);
			for (int n = 0; n < 2; n++) begin
				hit();
				rd(`TGAIC_OFS_STATUS, {6'h00, (c % 4 != 0), 3'h1, 5'h00, lvl(c, n)}, 16'h0241);
				bus(1'b1, `TGAIC_OFS_STATUS, 16'h01C0);
			end
		end
		// pin capture: rising, falling, both
		for (int c = 8; c < 12; c++) begin
			bus(1'b1, `TGAIC_OFS_FUNC1, 16'(c));
			idle(6);
			bus(1'b1, `TGAIC_OFS_GR1, 16'h0000);
			g = 16'h0000;
			for (int e = 1; e >= 0; e--) begin
				r = 16'($random(seed));
				cnt[0] <= r;
				ext_lvl[0] <= e[0];
				idle(6);
				if (c[1] || (c[0] != e[0]))
					g = r;
				rd(`TGAIC_OFS_GR1, g, 16'hFFFF);
			end
		end
		// cascaded sources, channel 2 stays on its pin
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 8'(4 * i), 16'h000C);
			bus(1'b1, 8'(4 * i + 12), 16'h0000);
		end
		// channel 2 keeps bit 2 as written even though capture ignores it
		rd(`TGAIC_OFS_FUNC2, 16'h000C, 16'hFFFF);
		g = 16'($random(seed));
		cnt <= {3{g}};
		pulse(0);
		rd(`TGAIC_OFS_GR1, g, 16'hFFFF);
		rd(`TGAIC_OFS_GR3, 16'h0000, 16'hFFFF);
		r = 16'($random(seed));
		cnt <= {3{r}};
		pulse(1);
		rd(`TGAIC_OFS_GR3, r, 16'hFFFF);
		rd(`TGAIC_OFS_GR2, 16'h0000, 16'hFFFF);
		r = 16'($random(seed));
		cnt <= {3{r}};
		ext_lvl <= 3'h3;
		idle(6);
		rd(`TGAIC_OFS_GR2, r, 16'hFFFF);
		rd(`TGAIC_OFS_GR1, g, 16'hFFFF);
		// sticky flags of all three captures and the synced undriven pin levels
		rd(`TGAIC_OFS_STATUS, 16'h01D8, 16'h01F8);
		idle(4);
		if (exp_q.size() != 0)
			mismatches++;
		report_and_stop();
	end
endmodule
